// ---- logic/seb_pkg.sv ----
package seb_pkg;

   // --------------------------------------------------------------
   // clock and timing
   // --------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   // internal programming cycle, in ms
   localparam int T_WR_MS = 10;
   // supply stable to first read or write, in ms
   localparam int POWER_UP_READ_DELAY_MS = 1;
   localparam int POWER_UP_WRITE_DELAY_MS = 1;
   localparam int POWER_UP_MS = (POWER_UP_READ_DELAY_MS > POWER_UP_WRITE_DELAY_MS) ?
                                POWER_UP_READ_DELAY_MS : POWER_UP_WRITE_DELAY_MS;
   // longest times round down; these come out exact
   localparam int WR_CYCLES = T_WR_MS * CYC_PER_MS;
   localparam int PU_CYCLES = POWER_UP_MS * CYC_PER_MS;
   localparam int CNT_W = 21;

   // --------------------------------------------------------------
   // bus framing and addressing
   // --------------------------------------------------------------
   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] DEV_TYPE = 4'ha;
   localparam int MEM_AW = 14;
   localparam int PAGE_AW = 6;
   localparam int PAGE_BYTES = 64;
   localparam int HI_AW = MEM_AW - 8;
   localparam logic [PAGE_AW-1:0] PAGE_FIRST = 6'h00;
   localparam logic [PAGE_AW-1:0] PAGE_LAST = 6'h3f;
   localparam logic [PAGE_AW-1:0] PAGE_STEP = 6'h01;

   // --------------------------------------------------------------
   // values after reset
   // --------------------------------------------------------------
   localparam logic [1:0] PIN_SYNC_RST = 2'h3;
   localparam logic [9:0] LINK_SYNC_RST = 10'h200;
   localparam logic BUSY_RST = 1'b1;
   localparam logic [CNT_W-1:0] CNT_RST = 21'h000000;
   localparam logic [MEM_AW-1:0] ADDR_RST = 14'h0000;
   localparam logic [PAGE_BYTES-1:0] MASK_RST = 64'h0;

   // --------------------------------------------------------------
   // state machines
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      LS_ADDR,
      LS_WADR_HI,
      LS_WADR_LO,
      LS_WDATA,
      LS_READ,
      LS_IGNORE
   } seb_link_st_e;

   typedef enum logic [1:0] {
      CS_POWERUP,
      CS_IDLE,
      CS_PROG,
      CS_WAIT
   } seb_ctl_st_e;

endpackage : seb_pkg

// ---- logic/seb_sync.sv ----
module seb_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset of the receiving domain
   input wire logic clk_i,
   input wire logic nrst_i,
   // level from elsewhere, level in this domain
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   import seb_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stab;
   } seb_sync_s;

   seb_sync_s s_q;
   seb_sync_s s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d.meta = d_i;
      s_d.stab = s_q.meta;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.stab;

endmodule : seb_sync

// ---- logic/seb_bus_slave.sv ----
module seb_bus_slave #(
   parameter int WR_CYCLES_P = seb_pkg::WR_CYCLES,
   parameter int PU_CYCLES_P = seb_pkg::PU_CYCLES
) (
   // system clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // two-wire bus, clock pin is the link clock
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // write-protect strap
   input wire logic wp_i,
   // byte to send in read mode, held by the array side
   input wire logic [7:0] rd_data_i,
   // array programming port
   output logic mem_we_o,
   output logic [seb_pkg::MEM_AW-1:0] mem_addr_o,
   output logic [7:0] mem_data_o,
   // programming or power-up in progress
   output logic busy_o
);
   import seb_pkg::*;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef struct packed {
      seb_link_st_e st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [7:0] tx;
      logic [MEM_AW-1:0] addr;
      logic [PAGE_BYTES-1:0] mask;
      logic ack;
      logic pending;
   } seb_link_s;

   typedef struct packed {
      seb_ctl_st_e st;
      logic scl_prev;
      logic sda_prev;
      logic link_run;
      logic armed;
      logic [CNT_W-1:0] cnt;
      logic [PAGE_AW-1:0] pos;
      logic [HI_AW+1:0] page;
      logic [PAGE_BYTES-1:0] mask;
      logic we;
      logic [MEM_AW-1:0] waddr;
      logic [7:0] wdata;
      logic busy;
      logic pull_lvl;
   } seb_ctl_s;

   seb_link_s l_q;
   seb_link_s l_d;
   seb_ctl_s c_q;
   seb_ctl_s c_d;
   logic sda_oe_q;
   logic [7:0] page_buf [PAGE_BYTES];
   logic [7:0] byte_v;
   logic buf_we;
   logic link_rst_n;
   logic scl_s;
   logic sda_s;
   logic busy_l;
   logic wp_l;
   logic [7:0] rd_l;
   logic start_ev;
   logic stop_ev;

   // ----------------------------------------------------------------
   // synchronisers
   // ----------------------------------------------------------------
   // bus pins seen from the system clock, idle high after reset
   seb_sync #(
      .WIDTH(2),
      .RST_VAL(PIN_SYNC_RST)
   ) u_pin_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i({scl_i, sda_i}),
      .q_o({scl_s, sda_s})
   );

   // levels seen from the link clock; busy assumed until known
   seb_sync #(
      .WIDTH(10),
      .RST_VAL(LINK_SYNC_RST)
   ) u_link_sync (
      .clk_i(scl_i),
      .nrst_i(link_rst_n),
      .d_i({c_q.busy, wp_i, rd_data_i}),
      .q_o({busy_l, wp_l, rd_l})
   );

   // link logic sits in reset outside frames
   assign link_rst_n = c_q.link_run;

   // ----------------------------------------------------------------
   // link side, clocked by the master's serial clock
   // ----------------------------------------------------------------
   // data is sampled on the rising clock edge only, so a value that
   // moves while the clock is high never reaches the shifter
   always_comb begin
      byte_v = {l_q.shreg[6:0], sda_i};
      buf_we = 1'b0;
      l_d = l_q;
      if (l_q.bitcnt != ACK_BIT) begin
         // data bit: shift in, and shift the transmit byte along
         l_d.bitcnt = l_q.bitcnt + 4'h1;
         l_d.shreg = byte_v;
         l_d.tx = {l_q.tx[6:0], 1'b0};
         if (l_q.bitcnt == BIT_LAST) begin
            l_d.ack = 1'b0;
            case (l_q.st)
               LS_ADDR: begin
                  // busy device ignores its own address
                  if ((byte_v[7:4] == DEV_TYPE) && !busy_l) begin
                     l_d.ack = 1'b1;
                  end
               end
               LS_WADR_HI, LS_WADR_LO: begin
                  l_d.ack = 1'b1;
               end
               LS_WDATA: begin
                  l_d.ack = !wp_l;
               end
               default: begin
                  l_d.ack = 1'b0;
               end
            endcase
         end
      end else begin
         // ninth clock: acknowledge slot
         l_d.bitcnt = BIT_FIRST;
         l_d.ack = 1'b0;
         case (l_q.st)
            LS_ADDR: begin
               if (!l_q.ack) begin
                  l_d.st = LS_IGNORE;
               end else if (l_q.shreg[0]) begin
                  l_d.st = LS_READ;
                  l_d.tx = rd_l;
               end else begin
                  l_d.st = LS_WADR_HI;
               end
            end
            LS_WADR_HI: begin
               l_d.addr[MEM_AW-1:8] = l_q.shreg[HI_AW-1:0];
               l_d.st = LS_WADR_LO;
            end
            LS_WADR_LO: begin
               l_d.addr[7:0] = l_q.shreg;
               l_d.st = LS_WDATA;
            end
            LS_WDATA: begin
               if (l_q.ack) begin
                  // only the in-page bits move, so a long page wraps
                  buf_we = 1'b1;
                  l_d.mask[l_q.addr[PAGE_AW-1:0]] = 1'b1;
                  l_d.pending = 1'b1;
                  l_d.addr[PAGE_AW-1:0] = l_q.addr[PAGE_AW-1:0] + PAGE_STEP;
               end else begin
                  // refused byte: no more data taken this frame
                  l_d.st = LS_IGNORE;
               end
            end
            LS_READ: begin
               // high on the ninth clock is no acknowledge from the master
               if (sda_i) begin
                  l_d.st = LS_IGNORE;
               end else begin
                  l_d.tx = rd_l;
               end
            end
            default: begin
               l_d.st = LS_IGNORE;
            end
         endcase
      end
   end

   // link state register, reset by the frame control below
   always_ff @(posedge scl_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         l_q.st <= LS_ADDR;
         l_q.bitcnt <= BIT_FIRST;
         l_q.shreg <= 8'h00;
         l_q.tx <= 8'h00;
         l_q.addr <= ADDR_RST;
         l_q.mask <= MASK_RST;
         l_q.ack <= 1'b0;
         l_q.pending <= 1'b0;
      end else begin
         l_q <= l_d;
      end
   end

   // page buffer; no reset, the mask says which bytes are real
   always_ff @(posedge scl_i) begin
      if (buf_we) begin
         page_buf[l_q.addr[PAGE_AW-1:0]] <= l_q.shreg;
      end
   end

   // the line only changes while the clock is low, hence falling edge;
   // only a pull low is ever driven, the pull-up makes the one
   always_ff @(negedge scl_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_oe_q <= 1'b0;
      end else if (l_q.bitcnt == ACK_BIT) begin
         sda_oe_q <= l_q.ack;
      end else begin
         sda_oe_q <= (l_q.st == LS_READ) && !l_q.tx[7];
      end
   end

   // ----------------------------------------------------------------
   // frame control and programming, on the system clock
   // ----------------------------------------------------------------
   // start and stop are found here because the serial clock gives no
   // edge after a stop; the link is held in reset between frames and
   // let go only once the clock has gone low after a start
   always_comb begin
      start_ev = scl_s && c_q.scl_prev && c_q.sda_prev && !sda_s;
      stop_ev = scl_s && c_q.scl_prev && !c_q.sda_prev && sda_s;
      c_d = c_q;
      c_d.scl_prev = scl_s;
      c_d.sda_prev = sda_s;
      c_d.we = 1'b0;
      if (start_ev) begin
         // a repeated start also restarts address matching
         c_d.link_run = 1'b0;
         c_d.armed = 1'b1;
      end else if (stop_ev) begin
         c_d.link_run = 1'b0;
         c_d.armed = 1'b0;
      end else if (c_q.armed && !scl_s) begin
         c_d.link_run = 1'b1;
         c_d.armed = 1'b0;
      end
      case (c_q.st)
         CS_POWERUP: begin
            c_d.cnt = c_q.cnt + CNT_W'(1);
            if (c_q.cnt == CNT_W'(PU_CYCLES_P - 1)) begin
               c_d.st = CS_IDLE;
               c_d.cnt = CNT_RST;
            end
         end
         CS_IDLE: begin
            // link state is still intact in the cycle of the stop
            if (stop_ev && c_q.link_run && l_q.pending) begin
               c_d.st = CS_PROG;
               c_d.page = l_q.addr[MEM_AW-1:PAGE_AW];
               c_d.mask = l_q.mask;
               c_d.pos = PAGE_FIRST;
               c_d.cnt = CNT_RST;
            end
         end
         CS_PROG: begin
            // walk the page once, writing only the bytes received
            c_d.cnt = c_q.cnt + CNT_W'(1);
            c_d.pos = c_q.pos + PAGE_STEP;
            if (c_q.mask[c_q.pos]) begin
               c_d.we = 1'b1;
               c_d.waddr = {c_q.page, c_q.pos};
               c_d.wdata = page_buf[c_q.pos];
            end
            if (c_q.pos == PAGE_LAST) begin
               c_d.st = CS_WAIT;
            end
         end
         CS_WAIT: begin
            c_d.cnt = c_q.cnt + CNT_W'(1);
            if (c_q.cnt == CNT_W'(WR_CYCLES_P - 1)) begin
               c_d.st = CS_IDLE;
               c_d.cnt = CNT_RST;
            end
         end
         default: begin
            c_d.st = CS_IDLE;
         end
      endcase
      c_d.busy = (c_d.st != CS_IDLE);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c_q.st <= CS_POWERUP;
         c_q.scl_prev <= 1'b1;
         c_q.sda_prev <= 1'b1;
         c_q.link_run <= 1'b0;
         c_q.armed <= 1'b0;
         c_q.cnt <= CNT_RST;
         c_q.pos <= PAGE_FIRST;
         c_q.page <= 8'h00;
         c_q.mask <= MASK_RST;
         c_q.we <= 1'b0;
         c_q.waddr <= ADDR_RST;
         c_q.wdata <= 8'h00;
         c_q.busy <= BUSY_RST;
         c_q.pull_lvl <= 1'b0;
      end else begin
         c_q <= c_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the pin is never driven high; output level stays low
   assign sda_o = c_q.pull_lvl;
   assign sda_oe_o = sda_oe_q;
   assign mem_we_o = c_q.we;
   assign mem_addr_o = c_q.waddr;
   assign mem_data_o = c_q.wdata;
   assign busy_o = c_q.busy;

endmodule : seb_bus_slave

// ---- verification/seb_bus_slave_checker.sv ----
module seb_bus_slave_checker import seb_pkg::*; #(
   parameter int WR_CYCLES_P = 800,
   parameter int PU_CYCLES_P = 400
) (
   // system side
   input wire logic clk_i,
   input wire logic nrst_i,
   // bus side
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic wp_i,
   input wire logic [7:0] rd_data_i,
   // array side
   input wire logic mem_we_o,
   input wire logic [seb_pkg::MEM_AW-1:0] mem_addr_o,
   input wire logic [7:0] mem_data_o,
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int bcnt_q;
   int rcnt_q;

   // busy run length and age since reset; counters avoid long repetitions
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bcnt_q <= 0;
         rcnt_q <= 0;
      end else begin
         bcnt_q <= busy_o ? bcnt_q + 1 : 0;
         rcnt_q <= (rcnt_q < PU_CYCLES_P) ? rcnt_q + 1 : rcnt_q;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   sequence s_scan_step;
      mem_we_o ##1 mem_we_o;
   endsequence

   sequence s_long_busy;
      bcnt_q >= 100;
   endsequence

   a_sda_low_only: assert property (sda_o == 1'b0)
      else $error("data line driven high");
   a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data enable moved while clock high");
   a_we_in_busy: assert property (mem_we_o |-> busy_o)
      else $error("array write outside programming");
   a_page_step: assert property (s_scan_step |->
      mem_addr_o[5:0] == $past(mem_addr_o[5:0]) + 6'h01 &&
      mem_addr_o[13:6] == $past(mem_addr_o[13:6]))
      else $error("page scan out of step");
   a_mem_hold: assert property ($changed({mem_addr_o, mem_data_o}) |-> mem_we_o)
      else $error("array port moved without write");
   a_busy_quiet: assert property (s_long_busy |-> !sda_oe_o)
      else $error("data line pulled while busy");
   a_busy_len: assert property ($fell(busy_o) |->
      (bcnt_q >= WR_CYCLES_P - 3 && bcnt_q <= WR_CYCLES_P + 3) ||
      (bcnt_q >= PU_CYCLES_P - 3 && bcnt_q <= PU_CYCLES_P + 3))
      else $error("busy period has wrong length");
   a_powerup_busy: assert property (rcnt_q < PU_CYCLES_P - 2 |-> busy_o)
      else $error("busy dropped during power-up");
endmodule : seb_bus_slave_checker

// ---- verification/seb_master_model.sv ----
module seb_master_model (
   // lines driven by the master, high means released
   output logic scl_o,
   output logic sda_o,
   // resolved data line
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle bus: clock stands still high between frames
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // one bit of 125 ns; data moves only while clock is low
   task automatic bitx(input logic b, output logic r);
      sda_o = b;
      #31;
      scl_o = 1'b1;
      r = sda_i;
      #62.5;
      scl_o = 1'b0;
      #31.5;
   endtask : bitx

   // start only from an idle bus
   task automatic start();
      sda_o = 1'b1;
      scl_o = 1'b1;
      #31;
      sda_o = 1'b0;
      #62;
      scl_o = 1'b0;
      #31;
   endtask : start

   task automatic stop();
      sda_o = 1'b0;
      #31;
      scl_o = 1'b1;
      #62;
      sda_o = 1'b1;
      #62;
   endtask : stop

   // send a byte msb first, return the level seen in the ninth slot
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(b[i], r);
      bitx(1'b1, ack);
   endtask : wbyte

   // receive a byte, then acknowledge low or leave released
   task automatic rbyte(input logic mack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, b[i]);
      bitx(mack, r);
   endtask : rbyte
endmodule : seb_master_model

// ---- verification/tb.sv ----
module tb import seb_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WR_CYC = 800;
   localparam int PU_CYC = 400;
   logic clk_i, nrst_i, wp_i, scl, sda, sda_m, sda_oe, sda_out, mem_we, busy;
   logic [7:0] rd_data, mem_data;
   logic [13:0] mem_addr;
   logic [7:0] wmem [0:16383];
   int miscompares, check_count, wcnt;

   // open-drain wire with pull-up
   assign sda = sda_m & (sda_oe ? sda_out : 1'b1);

   seb_bus_slave #(.WR_CYCLES_P(WR_CYC), .PU_CYCLES_P(PU_CYC)) i_seb_bus_slave (
      .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
      .sda_oe_o(sda_oe), .wp_i(wp_i), .rd_data_i(rd_data), .mem_we_o(mem_we),
      .mem_addr_o(mem_addr), .mem_data_o(mem_data), .busy_o(busy));
   seb_master_model i_seb_master_model (.scl_o(scl), .sda_o(sda_m), .sda_i(sda));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // record every array write, away from the edge that launches it
   always @(negedge clk_i) begin
      if (mem_we === 1'b1) begin
         wmem[mem_addr] = mem_data;
         wcnt++;
      end
   end

   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   // bounded wait for the end of programming
   task automatic wait_idle();
      int n;
      repeat (4) @(posedge clk_i);
      for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk_i);
      if (n == 4000) begin
         miscompares++;
         $display("CHECK FAILED busy wait expected 0 seen %b", busy);
         stop_test();
      end
   endtask : wait_idle

   // slave address, two address bytes, n data bytes, stop
   task automatic wframe(input logic [7:0] hi, lo, input int n, input logic [7:0] d0,
                         input logic dack);
      logic a;
      i_seb_master_model.start();
      i_seb_master_model.wbyte(8'ha0, a);
      chk("slave ack", a, 1'b0);
      i_seb_master_model.wbyte(hi, a);
      chk("high ack", a, 1'b0);
      i_seb_master_model.wbyte(lo, a);
      chk("low ack", a, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_seb_master_model.wbyte(8'(d0 + i), a);
         chk("data ack", a, dack);
      end
      i_seb_master_model.stop();
   endtask : wframe

   // address sent while power-up is still running
   task automatic t_powerup();
      logic a;
      chk("busy at start", busy, 1'b1);
      i_seb_master_model.start();
      i_seb_master_model.wbyte(8'ha0, a);
      chk("early ack", a, 1'b1);
      i_seb_master_model.stop();
      wait_idle();
   endtask : t_powerup

   // byte write then polling while busy and after
   task automatic t_byte();
      logic a;
      wcnt = 0;
      wframe(8'hd2, 8'h34, 1, 8'h5a, 1'b0);
      i_seb_master_model.start();
      i_seb_master_model.wbyte(8'ha0, a);
      chk("poll busy", a, 1'b1);
      i_seb_master_model.stop();
      wait_idle();
      chk("byte count", 16'(wcnt), 16'h1);
      chk("byte data", wmem[14'h1234], 8'h5a);
      i_seb_master_model.start();
      i_seb_master_model.wbyte(8'ha0, a);
      chk("poll done", a, 1'b0);
      i_seb_master_model.stop();
   endtask : t_byte

   // 66 bytes from position 62: wraps and overwrites
   task automatic t_page();
      wcnt = 0;
      wframe(8'h05, 8'hbe, 66, 8'h10, 1'b0);
      wait_idle();
      chk("page count", 16'(wcnt), 16'h40);
      chk("pos 62", wmem[14'h05be], 8'h50);
      chk("pos 63", wmem[14'h05bf], 8'h51);
      chk("pos 0", wmem[14'h0580], 8'h12);
      chk("pos 61", wmem[14'h05bd], 8'h4f);
   endtask : t_page

   // protected array: first data byte refused, nothing programmed
   task automatic t_wp();
      wcnt = 0;
      @(posedge clk_i);
      #1 wp_i = 1'b1;
      wframe(8'h01, 8'h00, 1, 8'hff, 1'b1);
      repeat (20) @(posedge clk_i);
      #1;
      chk("wp busy", busy, 1'b0);
      chk("wp count", 16'(wcnt), 16'h0);
      wp_i = 1'b0;
   endtask : t_wp

   // every don't-care code reads; foreign type codes are ignored
   task automatic t_addr();
      logic a;
      logic [7:0] b;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_i);
         #1 rd_data = 8'h5a - 8'(k);
         i_seb_master_model.start();
         i_seb_master_model.wbyte({4'ha, 3'(k), 1'b1}, a);
         chk("read select", a, 1'b0);
         i_seb_master_model.rbyte(1'b0, b);
         chk("read first", b, rd_data);
         i_seb_master_model.rbyte(1'b1, b);
         chk("read second", b, rd_data);
         i_seb_master_model.stop();
      end
      for (int k = 0; k < 2; k++) begin
         i_seb_master_model.start();
         i_seb_master_model.wbyte(k ? 8'hb0 : 8'h20, a);
         chk("foreign code", a, 1'b1);
         i_seb_master_model.stop();
      end
   endtask : t_addr

   initial begin
      nrst_i = 1'b0;
      wp_i = 1'b0;
      rd_data = 8'h00;
      miscompares = 0;
      check_count = 0;
      wcnt = 0;
      repeat (16) @(posedge clk_i);
      #1 nrst_i = 1'b1;
      t_powerup();
      t_byte();
      t_page();
      t_wp();
      t_addr();
      stop_test();
   end
endmodule : tb

bind seb_bus_slave seb_bus_slave_checker #(.WR_CYCLES_P(WR_CYCLES_P),
   .PU_CYCLES_P(PU_CYCLES_P)) i_seb_bus_slave_checker (.clk_i(clk_i), .nrst_i(nrst_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
   .rd_data_i(rd_data_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
   .mem_data_o(mem_data_o), .busy_o(busy_o));
